// ===== verification/logic_slice_tb_top.sv
// Self-checking bench for one logic slice beside a model of its neighbours.
// Assumes a single 20 MHz fabric clock and that the bench plays the control slice.
`timescale 1ns/10ps

module logic_slice_tb_top
	import slice_pkg::*;
;
	localparam logic [15:0] T0    = 16'hA5C3;
	localparam logic [15:0] T1    = 16'h3C96;
	localparam logic [31:0] NB_LO = 32'h6996A55A;
	localparam logic [31:0] NB_HI = 32'h0FF0C33C;
	logic         core_clk, reset_n, fce, lsr_async, cfg_load, ce, local_set_reset, carry_in, nb_carry;
	logic         we_in, fx5, wide, cout, cg, cp, ge, ne, le, wide_lo, wide_hi, we_out;
	mode_type     mode;
	arith_op_type op;
	ram_role_type role;
	logic [1:0]   set_val, mpi, f, q;
	logic [15:0]  init0, init1;
	logic [3:0]   t0_in, t1_in, wa_in, wd_in, wa_out, wd_out;
	logic [4:0]   nb_in;
	int           fail_count, n_compared;
	////////////////////////////////////////////////////////////////////////////////
	logic_slice u_logic_slice (
		.CORE_CLK(core_clk), .RESET_N(reset_n), .SLICE_MODE(mode), .ARITH_OP(op),
		.FAST_CARRY_ENABLE(fce), .LSR_ASYNC_CLEAR(lsr_async), .REG_SET_VALUE(set_val),
		.RAM_SLICE_ROLE(role), .CONFIG_LOAD(cfg_load), .TABLE0_INIT(init0),
		.TABLE1_INIT(init1), .TABLE0_INPUTS(t0_in), .TABLE1_INPUTS(t1_in),
		.MULTIPURPOSE_INPUTS(mpi), .CLOCK_ENABLE(ce), .LOCAL_SET_RESET(local_set_reset),
		.FAST_CARRY_INPUT(carry_in), .WIDE_MUX_IN_LOW(wide_lo), .WIDE_MUX_IN_HIGH(wide_hi),
		.RAM_WRITE_ADDRESS_IN(wa_in), .RAM_WRITE_DATA_IN(wd_in), .RAM_WRITE_ENABLE_IN(we_in),
		.TABLE_BYPASS_OUTPUTS(f), .REGISTER_OUTPUTS(q), .FIVE_INPUT_MUX_OUTPUT(fx5),
		.WIDE_MUX_OUTPUT(wide), .FAST_CARRY_OUTPUT(cout), .CARRY_GENERATE(cg),
		.CARRY_PROPAGATE(cp), .COMPARE_GE(ge), .COMPARE_NE(ne), .COMPARE_LE(le),
		.RAM_WRITE_ADDRESS(wa_out), .RAM_WRITE_DATA(wd_out), .RAM_WRITE_ENABLE(we_out));
	neighbour_fabric #(.LOW_TABLE(NB_LO), .HIGH_TABLE(NB_HI)) u_neighbour_fabric (
		.nb_inputs(nb_in), .nb_carry(nb_carry), .wide_low(wide_lo), .wide_high(wide_hi),
		.carry_out(carry_in));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("comparisons=%0d mismatches=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_logic();
		logic [5:0] i;
		logic [3:0] j;
		logic [4:0] n;
		@(posedge core_clk);
		init0 <= T0;
		init1 <= T1;
		cfg_load <= 1'b1;
		@(posedge core_clk);
		cfg_load <= 1'b0;
		for (int k = 0; k < 64; k++) begin
			i = k[5:0];
			j = ~i[3:0];
			n = {i[0], i[4:1]};
			@(posedge core_clk);
			t0_in <= i[3:0];
			t1_in <= j;
			mpi <= i[5:4];
			nb_in <= n;
			@(negedge core_clk);
			check(f, {T1[j], T0[i[3:0]]});
			check(fx5, i[4] ? T1[j] : T0[i[3:0]]);
			check(wide, i[5] ? NB_HI[n] : NB_LO[n]);
		end
		$display("t_logic done");
	endtask
	task automatic t_regs();
		@(posedge core_clk);
		t0_in <= 4'h0;
		t1_in <= 4'h1;
		ce <= 1'b1;
		@(posedge core_clk);
		ce <= 1'b0;
		t0_in <= 4'h5;
		@(posedge core_clk);
		local_set_reset <= 1'b1;
		set_val <= 2'h1;
		ce <= 1'b1;
		@(negedge core_clk);
		check(q, {T1[1], T0[0]});
		@(posedge core_clk);
		local_set_reset <= 1'b0;
		@(negedge core_clk);
		check(q, 2'h1);
		@(posedge core_clk);
		ce <= 1'b0;
		@(negedge core_clk);
		check(q, {T1[1], T0[5]});
		$display("t_regs done");
	endtask
	task automatic t_ripple();
		arith_op_type ops [7];
		logic [2:0]   sum, gp;
		logic [1:0]   a, b, bb;
		logic         sub, cin;
		// The two multiplier steps differ only in the multiplier bit on mpi[0]
		ops = '{OP_ADD, OP_SUB, OP_ADDSUB, OP_ADDSUB, OP_COMPARE, OP_MULT, OP_MULT};
		for (int fc = 0; fc < 2; fc++) begin
			for (int m = 0; m < 7; m++) begin
				for (int k = 0; k < 16; k++) begin
					a = k[1:0];
					b = k[3:2];
					sub = (m == 1) || (m == 2) || (m == 4);
					cin = (fc == 1) ? (a[0] ^ b[1]) : sub;
					bb = sub ? ~b : (m == 6) ? 2'h0 : b;
					sum = {1'b0, a} + {1'b0, bb} + {2'h0, cin};
					gp = {1'b0, a} + {1'b0, bb};
					@(posedge core_clk);
					mode <= MODE_RIPPLE;
					fce <= fc[0];
					op <= ops[m];
					mpi <= {1'b0, m == 2 || m == 5};
					t0_in <= {2'h0, b[0], a[0]};
					t1_in <= {2'h0, b[1], a[1]};
					nb_carry <= a[0] ^ b[1];
					@(negedge core_clk);
					check(f, sum[1:0]);
					check(cout, sum[2]);
					check({cg, cp}, fc ? {gp[2], &(a ^ bb)} : 2'h0);
					check({ge, ne, le}, (m == 4) ? {a >= b, a != b, a <= b} : 3'h0);
				end
			end
		end
		$display("t_ripple done");
	endtask
	task automatic t_count();
		arith_op_type ops [4];
		logic [1:0]   step, exp_q;
		ops = '{OP_UP, OP_DOWN, OP_UPDOWN, OP_UPDOWN};
		@(posedge core_clk);
		fce <= 1'b0;
		local_set_reset <= 1'b1;
		set_val <= 2'h3;
		ce <= 1'b0;
		@(posedge core_clk);
		local_set_reset <= 1'b0;
		@(negedge core_clk);
		exp_q = 2'h3;
		check(q, exp_q);
		for (int m = 0; m < 4; m++) begin
			step = (m == 0 || m == 3) ? 2'h1 : 2'h3;
			@(posedge core_clk);
			op <= ops[m];
			mpi <= {1'b0, m == 1 || m == 3};
			ce <= 1'b1;
			repeat (3) begin
				@(posedge core_clk);
				exp_q = exp_q + step;
				@(negedge core_clk);
				check(q, exp_q);
			end
			@(posedge core_clk);
			ce <= 1'b0;
			exp_q = exp_q + step;
		end
		// Preload takes the A operand, then the same register counts up from it
		@(posedge core_clk);
		op <= OP_PRELOAD;
		mpi <= 2'h2;
		t0_in <= 4'h0;
		t1_in <= 4'h1;
		ce <= 1'b1;
		@(posedge core_clk);
		mpi <= 2'h1;
		@(negedge core_clk);
		check(q, 2'h2);
		@(posedge core_clk);
		ce <= 1'b0;
		@(negedge core_clk);
		check(q, 2'h3);
		// Clear lands on a held count, so only the asynchronous path can zero it
		@(posedge core_clk);
		op <= OP_UPDOWN;
		lsr_async <= 1'b1;
		local_set_reset <= 1'b1;
		@(negedge core_clk);
		check(q, 2'h0);
		@(posedge core_clk);
		local_set_reset <= 1'b0;
		lsr_async <= 1'b0;
		$display("t_count done");
	endtask
	task automatic t_ram();
		logic [3:0] d;
		for (int r = 0; r < 2; r++) begin
			@(posedge core_clk);
			mode <= MODE_RAM;
			role <= r ? ROLE_DATA_HIGH : ROLE_DATA_LOW;
			for (int a = 0; a < 16; a++) begin
				@(posedge core_clk);
				we_in <= 1'b1;
				wa_in <= a[3:0];
				wd_in <= a[3:0] ^ (r ? 4'h9 : 4'h6);
			end
			@(posedge core_clk);
			we_in <= 1'b0;
			@(negedge core_clk);
			check({we_out, wd_out, wa_out}, 9'h000);
			for (int a = 0; a < 16; a++) begin
				d = a[3:0] ^ (r ? 4'h9 : 4'h6);
				@(posedge core_clk);
				t0_in <= a[3:0];
				t1_in <= a[3:0];
				@(negedge core_clk);
				check(f, r ? d[3:2] : d[1:0]);
			end
		end
		// A write strobe in ROM mode must leave the stored word untouched
		@(posedge core_clk);
		mode <= MODE_ROM;
		we_in <= 1'b1;
		wa_in <= 4'h5;
		wd_in <= 4'h0;
		t0_in <= 4'h5;
		t1_in <= 4'h5;
		@(posedge core_clk);
		we_in <= 1'b0;
		@(negedge core_clk);
		check(f, 2'h3);
		$display("t_ram done");
	endtask
	task automatic t_ctrl();
		@(posedge core_clk);
		mode <= MODE_RAM;
		role <= ROLE_CONTROL;
		t0_in <= 4'hA;
		t1_in <= 4'h5;
		local_set_reset <= 1'b1;
		@(negedge core_clk);
		check({we_out, wd_out, wa_out}, 9'h15A);
		@(posedge core_clk);
		local_set_reset <= 1'b0;
		@(negedge core_clk);
		check(we_out, 1'b0);
		$display("t_ctrl done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{fce, lsr_async, cfg_load, ce, local_set_reset, nb_carry, we_in} = 7'h00;
		{set_val, mpi, init0, init1, t0_in, t1_in, wa_in, wd_in, nb_in} = 57'h0;
		mode = MODE_LOGIC;
		op = OP_ADD;
		role = ROLE_DATA_LOW;
		fail_count = 0;
		n_compared = 0;
		reset_n = 1'b0;
		repeat (20) @(posedge core_clk);
		reset_n <= 1'b1;
		@(negedge core_clk);
		check(q, REG_RESET);
		t_logic();
		t_regs();
		t_ripple();
		t_count();
		t_ram();
		t_ctrl();
		final_report();
	end
	// Whole run needs well under a thousand cycles; a hang is cut off here
	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		final_report();
	end
endmodule

// ===== verification/neighbour_fabric.sv
// Model of the neighbouring slices seen by one slice: wide-mux results and carry.
// Assumes the bench chooses the neighbours' inputs; outputs follow combinationally.
`timescale 1ns/10ps

module neighbour_fabric #(
	parameter logic [31:0] LOW_TABLE  = 32'h6996A55A,
	parameter logic [31:0] HIGH_TABLE = 32'h0FF0C33C
) (
	input  wire logic [4:0] nb_inputs,
	input  wire logic       nb_carry,
	output wire logic       wide_low,
	output wire logic       wide_high,
	output wire logic       carry_out
);
	////////////////////////////////////////////////////////////////////////////////
	// Each neighbour offers a five-input function on its first wide output
	assign wide_low  = LOW_TABLE[nb_inputs];
	// The upper neighbour feeds the second mux level, as in a six-input cascade
	assign wide_high = HIGH_TABLE[nb_inputs];
	// Lower slice of the chain hands its carry on; no kinder than a real adder
	assign carry_out = nb_carry;
endmodule

// ===== verilog/logic_slice.sv
// One logic slice: two tables, wide muxes, ripple arithmetic and two registers.
// Assumes neighbours wire carry and wide-mux chains, and three slices form a RAM.
`timescale 1ns/10ps

module logic_slice
	import slice_pkg::*;
#(
	parameter int unsigned ADDR_W = TABLE_ADDR_W
) (
	input  wire logic                CORE_CLK,
	input  wire logic                RESET_N,
	input  wire mode_type            SLICE_MODE,
	input  wire arith_op_type        ARITH_OP,
	input  wire logic                FAST_CARRY_ENABLE,
	input  wire logic                LSR_ASYNC_CLEAR,
	input  wire logic [1:0]          REG_SET_VALUE,
	input  wire ram_role_type        RAM_SLICE_ROLE,
	input  wire logic                CONFIG_LOAD,
	input  wire logic [15:0]         TABLE0_INIT,
	input  wire logic [15:0]         TABLE1_INIT,
	input  wire logic [ADDR_W-1:0]   TABLE0_INPUTS,
	input  wire logic [ADDR_W-1:0]   TABLE1_INPUTS,
	input  wire logic [1:0]          MULTIPURPOSE_INPUTS,
	input  wire logic                CLOCK_ENABLE,
	input  wire logic                LOCAL_SET_RESET,
	input  wire logic                FAST_CARRY_INPUT,
	input  wire logic                WIDE_MUX_IN_LOW,
	input  wire logic                WIDE_MUX_IN_HIGH,
	input  wire logic [ADDR_W-1:0]   RAM_WRITE_ADDRESS_IN,
	input  wire logic [3:0]          RAM_WRITE_DATA_IN,
	input  wire logic                RAM_WRITE_ENABLE_IN,
	output wire logic [1:0]          TABLE_BYPASS_OUTPUTS,
	output wire logic [1:0]          REGISTER_OUTPUTS,
	output wire logic                FIVE_INPUT_MUX_OUTPUT,
	output wire logic                WIDE_MUX_OUTPUT,
	output wire logic                FAST_CARRY_OUTPUT,
	output wire logic                CARRY_GENERATE,
	output wire logic                CARRY_PROPAGATE,
	output wire logic                COMPARE_GE,
	output wire logic                COMPARE_NE,
	output wire logic                COMPARE_LE,
	output wire logic [ADDR_W-1:0]   RAM_WRITE_ADDRESS,
	output wire logic [3:0]          RAM_WRITE_DATA,
	output wire logic                RAM_WRITE_ENABLE
);

	if (ADDR_W != TABLE_ADDR_W) begin : g_bad_addr
		$error("logic_slice: tables must have four inputs");
	end
	if (RAM_SLICES != 3 || RAM_WIDTH != 2 * SLICE_BITS + 0) begin : g_bad_ram
		$error("logic_slice: RAM build needs three slices of two bits");
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode and role decode

	wire is_logic  = SLICE_MODE == MODE_LOGIC;
	wire is_ripple = SLICE_MODE == MODE_RIPPLE;
	wire is_ram    = SLICE_MODE == MODE_RAM;
	wire is_rom    = SLICE_MODE == MODE_ROM;

	wire role_low  = is_ram && RAM_SLICE_ROLE == ROLE_DATA_LOW;
	wire role_high = is_ram && RAM_SLICE_ROLE == ROLE_DATA_HIGH;
	wire role_ctrl = is_ram && RAM_SLICE_ROLE == ROLE_CONTROL;
	wire role_data = role_low || role_high;

	function automatic logic op_is(input arith_op_type op);
		op_is = is_ripple && ARITH_OP == op;
	endfunction

	wire op_add     = op_is(OP_ADD);
	wire op_sub     = op_is(OP_SUB);
	wire op_addsub  = op_is(OP_ADDSUB);
	wire op_up      = op_is(OP_UP);
	wire op_down    = op_is(OP_DOWN);
	wire op_updown  = op_is(OP_UPDOWN);
	wire op_preload = op_is(OP_PRELOAD);
	wire op_mult    = op_is(OP_MULT);
	wire op_compare = op_is(OP_COMPARE);

	wire dir_up   = MULTIPURPOSE_INPUTS[0];
	wire load_req = MULTIPURPOSE_INPUTS[1];

	////////////////////////////////////////////////////////////////////////////
	// Distributed memory controls

	// A control slice hands its own inputs to the two data slices
	assign RAM_WRITE_ADDRESS = role_ctrl ? TABLE0_INPUTS : '0;
	assign RAM_WRITE_DATA    = role_ctrl ? TABLE1_INPUTS : '0;
	assign RAM_WRITE_ENABLE  = role_ctrl && LOCAL_SET_RESET;

	// Each data slice picks its own pair of the four data bits
	wire [1:0] wr_pair = role_high ?
		RAM_WRITE_DATA_IN[DATA_HIGH_POS +: 2] :
		RAM_WRITE_DATA_IN[DATA_LOW_POS +: 2];

	// Writes stay off in ROM and logic modes, so contents only change by loading
	wire table_we = role_data && RAM_WRITE_ENABLE_IN;

	////////////////////////////////////////////////////////////////////////////
	// Lookup tables

	wire [15:0]       init_vec [2];
	wire [ADDR_W-1:0] rd_addr  [2];
	wire [1:0]        table_out;

	assign init_vec[0] = TABLE0_INIT;
	assign init_vec[1] = TABLE1_INIT;
	assign rd_addr[0]  = TABLE0_INPUTS;
	assign rd_addr[1]  = TABLE1_INPUTS;

	for (genvar k = 0; k < SLICE_BITS; k++) begin : g_table
		lut_table #(
			.ADDR_W        (ADDR_W)
		) u_table (
			.clk           (CORE_CLK),
			.init_load     (CONFIG_LOAD),
			.init_value    (init_vec[k]),
			.write_enable  (table_we),
			.write_address (RAM_WRITE_ADDRESS_IN),
			.write_data    (wr_pair[k]),
			.read_address  (rd_addr[k]),
			.read_data     (table_out[k])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Wide function muxes

	assign FIVE_INPUT_MUX_OUTPUT = dir_up ? table_out[1] : table_out[0];
	// Neighbours feed their wide outputs here to build six to eight inputs
	assign WIDE_MUX_OUTPUT = load_req ? WIDE_MUX_IN_HIGH : WIDE_MUX_IN_LOW;

	////////////////////////////////////////////////////////////////////////////
	// Ripple arithmetic

	logic [1:0] reg_q;
	logic [1:0] reg_d;

	wire is_count = op_up || op_down || op_updown || op_preload;
	wire [1:0] opnd_a = {TABLE1_INPUTS[0], TABLE0_INPUTS[0]};
	wire [1:0] opnd_b = {TABLE1_INPUTS[1], TABLE0_INPUTS[1]};

	wire do_sub = op_sub || (op_addsub && dir_up) || op_down ||
		((op_updown || op_preload) && !dir_up) || op_compare;

	wire [1:0] arg_a = is_count ? reg_q : opnd_a;
	// Multiplier step adds B to the partial product on A when its multiplier bit is set
	wire [1:0] arg_b = is_count ? COUNT_STEP :
		op_mult ? (opnd_b & {2{dir_up}}) : opnd_b;
	wire [1:0] b_eff = do_sub ? ~arg_b : arg_b;

	// Without fast carry the slice stands alone; subtraction injects its own one
	wire carry_in = FAST_CARRY_ENABLE ? FAST_CARRY_INPUT : do_sub;

	wire [1:0] gen  = arg_a & b_eff;
	wire [1:0] prop = arg_a ^ b_eff;
	wire       c_mid = gen[0] | (prop[0] & carry_in);
	wire       c_out = gen[1] | (prop[1] & c_mid);
	wire [1:0] sum   = prop ^ {c_mid, carry_in};

	wire grp_gen  = gen[1] | (prop[1] & gen[0]);
	wire grp_prop = prop[1] & prop[0];

	assign CARRY_GENERATE    = is_ripple && FAST_CARRY_ENABLE && grp_gen;
	assign CARRY_PROPAGATE   = is_ripple && FAST_CARRY_ENABLE && grp_prop;
	assign FAST_CARRY_OUTPUT = is_ripple && c_out;

	assign COMPARE_GE = op_compare && opnd_a >= opnd_b;
	assign COMPARE_NE = op_compare && opnd_a != opnd_b;
	assign COMPARE_LE = op_compare && opnd_a <= opnd_b;

	wire [1:0] ripple_out = (op_preload && load_req) ? opnd_a : sum;

	////////////////////////////////////////////////////////////////////////////
	// Bypass outputs and registers

	wire [1:0] slice_f = is_ripple ? ripple_out : table_out;
	assign TABLE_BYPASS_OUTPUTS = slice_f;

	// Async clear only in ripple mode; the control slice spends its set/reset on writes
	wire async_clr = LOCAL_SET_RESET && LSR_ASYNC_CLEAR && is_ripple;
	wire clr_n     = RESET_N && !async_clr;
	wire lsr_sync  = LOCAL_SET_RESET && !LSR_ASYNC_CLEAR && !role_ctrl;

	assign reg_d = lsr_sync ? REG_SET_VALUE :
		CLOCK_ENABLE ? slice_f : reg_q;

	always_ff @(posedge CORE_CLK or negedge clr_n) begin
		if (!clr_n) begin
			reg_q <= REG_RESET;
		end else begin
			reg_q <= reg_d;
		end
	end

	assign REGISTER_OUTPUTS = reg_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);

	chk_table_logic: assert property (
		$past(CONFIG_LOAD) && is_logic && $stable(TABLE0_INPUTS)
		|-> TABLE_BYPASS_OUTPUTS[0] == $past(TABLE0_INIT[TABLE0_INPUTS])
	) else $error("table output differs from loaded truth table");

	chk_five_mux: assert property (
		is_logic |-> FIVE_INPUT_MUX_OUTPUT ==
			(dir_up ? TABLE_BYPASS_OUTPUTS[1] : TABLE_BYPASS_OUTPUTS[0])
	) else $error("five-input mux does not follow table outputs");

	chk_wide_cascade: assert property (
		load_req && WIDE_MUX_IN_HIGH != WIDE_MUX_IN_LOW
		|-> WIDE_MUX_OUTPUT == WIDE_MUX_IN_HIGH
	) else $error("wide mux picked the wrong neighbour");

	chk_reg_hold: assert property (
		!CLOCK_ENABLE && !LOCAL_SET_RESET ##1 !async_clr
		|-> $stable(REGISTER_OUTPUTS)
	) else $error("register moved without clock enable");

	chk_reg_setreset: assert property (
		lsr_sync ##1 !async_clr |-> REGISTER_OUTPUTS == $past(REG_SET_VALUE)
	) else $error("set/reset did not force configured value");

	chk_add_sum: assert property (
		op_add && !FAST_CARRY_ENABLE
		|-> {FAST_CARRY_OUTPUT, TABLE_BYPASS_OUTPUTS} == 3'(opnd_a) + 3'(opnd_b)
	) else $error("two-bit sum is wrong");

	chk_up_count: assert property (
		op_up && CLOCK_ENABLE && !LOCAL_SET_RESET && !FAST_CARRY_ENABLE
		##1 !async_clr |-> REGISTER_OUTPUTS == 2'($past(REGISTER_OUTPUTS) + 2'h1)
	) else $error("up counter did not step by one");

	chk_fast_carry: assert property (
		is_ripple && FAST_CARRY_ENABLE
		|-> FAST_CARRY_OUTPUT == (CARRY_GENERATE | (CARRY_PROPAGATE & FAST_CARRY_INPUT))
	) else $error("carry out disagrees with generate and propagate");

	chk_compare_set: assert property (
		op_compare |-> (COMPARE_GE && COMPARE_LE) == !COMPARE_NE &&
			(COMPARE_GE || COMPARE_LE)
	) else $error("comparator flags inconsistent");

	chk_ram_write: assert property (
		role_data && RAM_WRITE_ENABLE_IN && !CONFIG_LOAD &&
		RAM_WRITE_ADDRESS_IN == TABLE0_INPUTS
		##1 role_data && $stable(TABLE0_INPUTS)
		|-> TABLE_BYPASS_OUTPUTS[0] == $past(wr_pair[0])
	) else $error("memory bit not written at the given address");

	chk_ctrl_route: assert property (
		role_ctrl |-> RAM_WRITE_ADDRESS == TABLE0_INPUTS &&
			RAM_WRITE_ENABLE == LOCAL_SET_RESET
	) else $error("control slice did not drive memory controls");

	chk_rom_fixed: assert property (
		is_rom ##1 is_rom && !$past(CONFIG_LOAD) && $stable(TABLE0_INPUTS) &&
		$stable(TABLE1_INPUTS) |-> $stable(TABLE_BYPASS_OUTPUTS)
	) else $error("ROM contents changed without loading");

	cov_ram_write: cover property (role_high && RAM_WRITE_ENABLE_IN);
	cov_count_load: cover property (op_preload && load_req && CLOCK_ENABLE);
	cov_carry_chain: cover property (is_ripple && FAST_CARRY_ENABLE && CARRY_PROPAGATE);
	cov_async_clear: cover property (LSR_ASYNC_CLEAR && LOCAL_SET_RESET && op_updown);

endmodule

// ===== verilog/lut_table.sv
// One lookup table: a small array read by address, written on the clock.
// Assumes init_load and write_enable are never wanted in the same cycle.
`timescale 1ns/10ps

module lut_table #(
	parameter int unsigned ADDR_W = 4
) (
	input  wire logic                  clk,
	input  wire logic                  init_load,
	input  wire logic [(1<<ADDR_W)-1:0] init_value,
	input  wire logic                  write_enable,
	input  wire logic [ADDR_W-1:0]     write_address,
	input  wire logic                  write_data,
	input  wire logic [ADDR_W-1:0]     read_address,
	output wire logic                  read_data
);

	if (ADDR_W < 1 || ADDR_W > 6) begin : g_bad_width
		$error("lut_table: ADDR_W must lie between 1 and 6");
	end

	// Contents are configuration, so they take no reset
	logic mem_q [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk) begin
		for (int i = 0; i < (1<<ADDR_W); i++) begin
			if (init_load) begin
				mem_q[i] <= init_value[i];
			end else if (write_enable && write_address == ADDR_W'(i)) begin
				mem_q[i] <= write_data;
			end
		end
	end

	assign read_data = mem_q[read_address];

endmodule

// ===== verilog/slice_pkg.sv
// Shared constants and types for the logic slice and its lookup tables.
// Assumes one fabric clock; all slice inputs come from logic on that clock.
//
// Functional notes
// - Slice runs in logic, ripple, RAM or ROM mode, chosen by configuration.
// - Each four-input table gives any function through a sixteen-entry truth table.
// - Two tables combine through a mux into a five-input function output.
// - Six to eight input functions cascade wide muxes across several slices.
// - Table results appear unregistered, apart from the two register outputs.
// - First wide output carries five inputs; second carries six, seven or eight.
// - Ripple mode adds, subtracts, dynamic add/subtract and counts up or down.
// - Ripple mode offers async-clear counter, sync-preload counter, multiplier step.
// - Ripple mode compares A and B: greater-equal, not-equal, less-equal.
// - Fast carry makes generate and propagate terms; carry chains in and out.
// - RAM mode: each table of two slices is 16x1, together 16x4 memory.
// - Control slice supplies memory controls: slice clock writes, set/reset enables.
// - Control slice routes data bits 3:2 to second slice, 1:0 to first.
// - Write address is the four table inputs of the control slice.
// - A 16x4 single-port or pseudo dual-port memory takes exactly three slices.
// - Memory contents load from configuration before operation begins.

package slice_pkg;

	localparam int unsigned TABLE_ADDR_W = 4;
	localparam int unsigned TABLE_DEPTH  = 16;
	localparam int unsigned SLICE_BITS   = 2;
	localparam int unsigned RAM_WIDTH    = 4;
	localparam int unsigned RAM_SLICES   = 3;

	localparam logic [1:0] REG_RESET     = 2'h0;
	localparam logic [1:0] COUNT_STEP    = 2'h1;
	localparam int unsigned DATA_LOW_POS  = 0;
	localparam int unsigned DATA_HIGH_POS = 2;

	typedef enum logic [3:0] {
		MODE_LOGIC  = 4'h1,
		MODE_RIPPLE = 4'h2,
		MODE_RAM    = 4'h4,
		MODE_ROM    = 4'h8
	} mode_type;

	typedef enum logic [8:0] {
		OP_ADD     = 9'h001,
		OP_SUB     = 9'h002,
		OP_ADDSUB  = 9'h004,
		OP_UP      = 9'h008,
		OP_DOWN    = 9'h010,
		OP_UPDOWN  = 9'h020,
		OP_PRELOAD = 9'h040,
		OP_MULT    = 9'h080,
		OP_COMPARE = 9'h100
	} arith_op_type;

	typedef enum logic [2:0] {
		ROLE_DATA_LOW  = 3'h1,
		ROLE_DATA_HIGH = 3'h2,
		ROLE_CONTROL   = 3'h4
	} ram_role_type;

endpackage
